// ### src/secure_mode_pkg.sv
// Package with constants and types of the secure mode state machine.
package secure_mode_pkg;

    // ----------------------------------------------------------------
    // Modes
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_OPEN   = 2'h0,
        MODE_ENTRY  = 2'h1,
        MODE_SECURE = 2'h2
    } mode_type;

    // ----------------------------------------------------------------
    // Widths and address ranges
    // ----------------------------------------------------------------
    localparam int ADDR_WIDTH = 32;
    localparam int SWITCH_WIDTH = 8;
    localparam logic [31:0] FW_BASE = 32'hFFA1_0000;
    localparam logic [31:0] FW_LIMIT = 32'hFFA1_3FFF;

    // ----------------------------------------------------------------
    // Switch settings
    // ----------------------------------------------------------------
    localparam logic [7:0] SWITCH_OPEN = 8'h00;
    localparam logic [7:0] SWITCH_RESTRICTED = 8'hFF;

endpackage

// ### src/pc_range_check.sv
// Program counter range comparator for the security firmware window.
`timescale 1ns/1ps
`default_nettype none
module pc_range_check (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // Program counter stream
    input wire logic pc_valid_in,
    input wire logic [31:0] pc_in,
    input wire logic enable_in,
    // Result
    output logic violation_out
);
    // Range comparison on a valid fetch.
    wire in_range = (pc_in >= secure_mode_pkg::FW_BASE) && (pc_in <= secure_mode_pkg::FW_LIMIT);
    wire next_violation = enable_in && pc_valid_in && !in_range;

    // Registered flag, one cycle after the offending fetch.
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            violation_out <= 1'b0;
        end else begin
            violation_out <= next_violation;
        end
    end
endmodule
`default_nettype wire

// ### src/secure_mode_state_machine.sv
// Three-mode security state machine that gates debug, DMA and private OTP.
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module secure_mode_state_machine (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // Firmware requests
    input wire logic entry_call_in,
    input wire logic digest_match_in,
    input wire logic digest_mismatch_in,
    // Program counter
    input wire logic pc_valid_in,
    input wire logic [31:0] pc_in,
    // Secure system switches
    input wire logic switch_write_in,
    input wire logic [7:0] switch_wdata_in,
    output logic [7:0] switch_out,
    // Access gates
    input wire logic dma_request_in,
    output logic dma_grant_out,
    input wire logic private_otp_request_in,
    output logic private_otp_grant_out,
    input wire logic public_otp_write_in,
    input wire logic public_otp_lock_in,
    output logic public_otp_write_grant_out,
    output logic public_otp_locked_out,
    // Test access port
    input wire logic tap_private_instr_in,
    output logic tap_private_enable_out,
    output logic emulator_enable_out,
    // Status
    output logic [1:0] mode_out,
    output logic auth_fail_out,
    output logic l1_copy_enable_out
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    secure_mode_pkg::mode_type mode;
    secure_mode_pkg::mode_type next_mode;
    logic [7:0] switches;
    logic [7:0] next_switches;
    logic otp_locked;
    logic fail_flag;
    logic pc_violation;

    // Range checker flags a program counter outside the firmware window, only while in Secure Entry.
    pc_range_check range_check (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .pc_valid_in(pc_valid_in),
        .pc_in(pc_in),
        .enable_in(mode == secure_mode_pkg::MODE_ENTRY),
        .violation_out(pc_violation)
    );

    // ----------------------------------------------------------------
    // Mode decoding
    // ----------------------------------------------------------------
    wire in_open = (mode == secure_mode_pkg::MODE_OPEN);
    wire in_entry = (mode == secure_mode_pkg::MODE_ENTRY);
    wire in_secure = (mode == secure_mode_pkg::MODE_SECURE);
    wire fail_event = in_entry && (pc_violation || digest_mismatch_in);

    // Next mode: an entry call is accepted only from Open Mode.
    always_comb begin
        next_mode = mode;
        unique case (mode)
            secure_mode_pkg::MODE_OPEN: begin
                if (entry_call_in) begin
                    next_mode = secure_mode_pkg::MODE_ENTRY;
                end
            end
            secure_mode_pkg::MODE_ENTRY: begin
                if (fail_event) begin
                    next_mode = secure_mode_pkg::MODE_OPEN;
                end else if (digest_match_in) begin
                    next_mode = secure_mode_pkg::MODE_SECURE;
                end
            end
            secure_mode_pkg::MODE_SECURE: begin
                next_mode = secure_mode_pkg::MODE_SECURE;
            end
            default: begin
                next_mode = secure_mode_pkg::MODE_OPEN;
            end
        endcase
    end

    // Switches follow the mode they are entering; only Secure lets code write them.
    always_comb begin
        next_switches = switches;
        if (next_mode == secure_mode_pkg::MODE_OPEN) begin
            next_switches = secure_mode_pkg::SWITCH_OPEN;
        end else if (in_open && next_mode == secure_mode_pkg::MODE_ENTRY) begin
            next_switches = secure_mode_pkg::SWITCH_RESTRICTED;
        end else if (in_secure && switch_write_in) begin
            next_switches = switch_wdata_in;
        end
    end

    // Mode and switch registers, reset into Open Mode.
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mode <= secure_mode_pkg::MODE_OPEN;
            switches <= secure_mode_pkg::SWITCH_OPEN;
        end else begin
            mode <= next_mode;
            switches <= next_switches;
        end
    end

    // Failure flag: set on failure, cleared by the next entry call.
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            fail_flag <= 1'b0;
        end else if (fail_event) begin
            fail_flag <= 1'b1;
        end else if (in_open && entry_call_in) begin
            fail_flag <= 1'b0;
        end
    end

    // Public OTP lock is sticky until reset; this register only models the lock bit.
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            otp_locked <= 1'b0;
        end else if (public_otp_lock_in) begin
            otp_locked <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Access gates
    // ----------------------------------------------------------------
    assign dma_grant_out = dma_request_in && !in_entry;
    assign private_otp_grant_out = private_otp_request_in && in_secure;
    assign public_otp_write_grant_out = public_otp_write_in && !otp_locked;
    assign tap_private_enable_out = tap_private_instr_in && in_open;
    assign emulator_enable_out = in_open;
    assign l1_copy_enable_out = in_secure;
    assign public_otp_locked_out = otp_locked;
    assign switch_out = switches;
    assign mode_out = mode;
    assign auth_fail_out = fail_flag;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);

    legal_mode_a: assert property (mode != 2'h3) else $error("illegal mode code");
    entry_call_a: assert property (in_open && entry_call_in |=> in_entry
        && switches == 8'hFF) else $error("entry call not taken");
    entry_restrict_a: assert property (in_entry |-> !emulator_enable_out
        && !dma_grant_out) else $error("debug or dma open in entry");
    dma_block_a: assert property (in_entry && dma_request_in |-> !dma_grant_out)
        else $error("dma granted in entry");
    pc_fail_a: assert property (in_entry && pc_valid_in && pc_in > secure_mode_pkg::FW_LIMIT
        |=> ##1 in_open && fail_flag) else $error("pc escape not failed");
    mismatch_a: assert property (in_entry && digest_mismatch_in |=> in_open && fail_flag
        && switches == 8'h00) else $error("mismatch not failed");
    match_a: assert property (in_entry && digest_match_in && !pc_violation && !digest_mismatch_in
        |=> in_secure) else $error("match not secured");
    private_otp_a: assert property (private_otp_grant_out |-> in_secure)
        else $error("private otp outside secure");
    tap_private_a: assert property (!in_open |-> !tap_private_enable_out)
        else $error("private tap in secure modes");
    open_switch_a: assert property (in_open |-> switches == 8'h00)
        else $error("open switches not cleared");
    switch_write_a: assert property (in_secure && switch_write_in
        |=> switches == $past(switch_wdata_in)) else $error("switch write lost");
    otp_lock_a: assert property (otp_locked |=> otp_locked && !public_otp_write_grant_out)
        else $error("lock released");

    secure_reached_c: cover property (in_entry ##1 in_secure);
    fail_retry_c: cover property (fail_flag && in_open ##1 in_entry);
    pc_escape_c: cover property (pc_violation && in_entry);
    secure_write_c: cover property (in_secure && switch_write_in);
    mismatch_fail_c: cover property (in_entry && digest_mismatch_in);

    // ----------------------------------------------------------------
    // Further assertions on gates, flags and holding behaviour
    // ----------------------------------------------------------------

    // The emulator is usable all through Open Mode.
    emulator_open_a: assert property (
        in_open |-> emulator_enable_out)
        else $error("emulator closed in open");

    // The emulator is shut in both protected modes.
    emulator_closed_a: assert property (
        !in_open |-> !emulator_enable_out)
        else $error("emulator open in protected mode");

    // A private test instruction is honoured in Open Mode.
    tap_open_a: assert property (
        in_open && tap_private_instr_in |-> tap_private_enable_out)
        else $error("private tap refused in open");

    // DMA outside Secure Entry passes straight through.
    dma_open_a: assert property (
        !in_entry && dma_request_in |-> dma_grant_out)
        else $error("dma refused outside entry");

    // The private OTP area stays shut outside Secure Mode.
    private_block_a: assert property (
        !in_secure |-> !private_otp_grant_out)
        else $error("private otp open outside secure");

    // A private OTP request in Secure Mode is granted.
    private_open_a: assert property (
        in_secure && private_otp_request_in |-> private_otp_grant_out)
        else $error("private otp refused in secure");

    // The code copy permission follows Secure Mode exactly.
    l1_copy_a: assert property (
        l1_copy_enable_out == in_secure)
        else $error("copy permission wrong");

    // Secure Mode is left only through reset.
    secure_hold_a: assert property (
        in_secure |=> in_secure)
        else $error("secure mode left");

    // A repeated entry call during Secure Entry changes nothing.
    entry_refused_a: assert property (
        in_entry && entry_call_in && !fail_event && !digest_match_in |=> in_entry)
        else $error("entry call taken in entry");

    // Switches stay restricted while authentication goes on.
    entry_switch_a: assert property (
        in_entry && !fail_event |=> switches == secure_mode_pkg::SWITCH_RESTRICTED)
        else $error("entry switches not restricted");

    // A new entry call clears the old failure.
    fail_clear_a: assert property (
        in_open && entry_call_in |=> !fail_flag)
        else $error("failure not cleared");

    // A failure stays visible until the next entry call.
    fail_hold_a: assert property (
        fail_flag && in_open && !entry_call_in |=> fail_flag)
        else $error("failure lost");

    // Secure Mode is only ever reached without a pending failure.
    secure_no_fail_a: assert property (
        in_secure |-> !fail_flag)
        else $error("failure seen in secure");

    // A fetch inside the firmware window does not fail the run.
    in_range_a: assert property (
        in_entry && pc_valid_in && pc_in >= secure_mode_pkg::FW_BASE
        && pc_in <= secure_mode_pkg::FW_LIMIT && !digest_mismatch_in && !pc_violation
        |=> !in_open)
        else $error("in range fetch failed");

    // Unlocked key area accepts writes.
    otp_write_a: assert property (
        !otp_locked && public_otp_write_in |-> public_otp_write_grant_out)
        else $error("unlocked write refused");

    // A lock request takes hold on the next edge.
    lock_set_a: assert property (
        public_otp_lock_in |=> otp_locked)
        else $error("lock not set");

    // The mode output mirrors the mode register.
    mode_out_a: assert property (
        mode_out == mode)
        else $error("mode output wrong");

    // Open Mode shows unrestricted switches at the port.
    open_out_a: assert property (
        in_open |-> switch_out == secure_mode_pkg::SWITCH_OPEN)
        else $error("open switch output wrong");

    // Reset holds Open Mode and its settings while low.
    reset_open_a: assert property (
        disable iff (1'b0) !reset_n_in |-> in_open
        && switches == secure_mode_pkg::SWITCH_OPEN && !fail_flag)
        else $error("reset state wrong");

endmodule
`default_nettype wire

// ### tb/core_model.sv
// Behavioural processor core that streams program counter samples.
`timescale 1ns/1ps
`default_nettype none
module core_model (
    // Clock
    input wire logic core_clk_in,
    // Bench command: vector outside the routine
    input wire logic stray_in,
    // Program counter stream
    output logic pc_valid_out,
    output logic [31:0] pc_out
);
    logic [13:0] offset = 14'h0;

    // A random fetch offset each falling edge, so a sample can repeat the last one.
    always @(negedge core_clk_in) begin
        offset <= 14'($urandom);
    end

    // Routine code stays in the window; a stray vector lands just above it.
    assign pc_valid_out = 1'b1;
    assign pc_out = stray_in ? secure_mode_pkg::FW_LIMIT + 32'h1 + 32'(offset)
                             : secure_mode_pkg::FW_BASE + 32'(offset);
endmodule
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the secure mode state machine.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_errors++; \
    $display("[ERR] %0t outputs %h expected %h", $time, got, exp); end end
module tb;
    logic core_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic ec = 1'b0, dm = 1'b0, dmm = 1'b0, stray = 1'b0, wr = 1'b0, lk = 1'b0;
    logic dreq = 1'b0, oreq = 1'b0, pwr = 1'b0, treq = 1'b0;
    logic [7:0] wd = 8'h00;
    logic pcv, dg, og, pg, lkd, tg, emu, fail, l1;
    logic [31:0] pc;
    logic [7:0] sw_o;
    logic [1:0] mode_o;
    logic [1:0] md;
    logic [7:0] sw;
    logic fl, lk_q, viol;
    logic [17:0] exp_v;
    logic [17:0] q[$];
    int n_errors = 0;
    int check_count = 0;
    event chk_ev;

    secure_mode_state_machine u_dut (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
        .entry_call_in(ec), .digest_match_in(dm), .digest_mismatch_in(dmm),
        .pc_valid_in(pcv), .pc_in(pc), .switch_write_in(wr), .switch_wdata_in(wd),
        .switch_out(sw_o), .dma_request_in(dreq), .dma_grant_out(dg),
        .private_otp_request_in(oreq), .private_otp_grant_out(og),
        .public_otp_write_in(pwr), .public_otp_lock_in(lk), .public_otp_write_grant_out(pg),
        .public_otp_locked_out(lkd), .tap_private_instr_in(treq),
        .tap_private_enable_out(tg), .emulator_enable_out(emu), .mode_out(mode_o),
        .auth_fail_out(fail), .l1_copy_enable_out(l1));
    core_model u_core (.core_clk_in(core_clk_in), .stray_in(stray), .pc_valid_out(pcv),
        .pc_out(pc));

    // Clock at 125 MHz.
    always #4 core_clk_in = ~core_clk_in;

    // Notes the expected output picture for the current mode and requests.
    task automatic note;
        {dreq, oreq, pwr, treq} = 4'($urandom);
        #1;
        q.push_back({md, sw, fl, dreq && md != 2'h1, oreq && md == 2'h2, treq && md == 2'h0,
            md == 2'h0, md == 2'h2, lk_q, pwr && !lk_q});
        -> chk_ev;
    endtask

    // One cycle of firmware activity, then the reference model follows the edge.
    task automatic step(input logic e, m, mm, b, w, l, input logic [7:0] d);
        logic nv;
        @(negedge core_clk_in);
        {ec, dm, dmm, stray, wr, lk, wd} = {e, m, mm, b, w, l, d};
        note();
        @(posedge core_clk_in);
        nv = b && md == 2'h1;
        if (md == 2'h0 && e) {md, sw, fl} = {2'h1, 8'hFF, 1'b0};
        else if (md == 2'h1 && (mm || viol)) {md, sw, fl} = {2'h0, 8'h00, 1'b1};
        else if (md == 2'h1 && m) md = 2'h2;
        else if (md == 2'h2 && w) sw = d;
        viol = nv;
        lk_q = lk_q | l;
    endtask

    // Asynchronous reset held for three cycles; outputs checked while it is low.
    task automatic rst;
        @(negedge core_clk_in);
        reset_n_in = 1'b0;
        {md, sw, fl, lk_q, viol} = '0;
        note();
        repeat (3) @(negedge core_clk_in);
        reset_n_in = 1'b1;
    endtask

    // Compares each output picture with the oldest note.
    always @(chk_ev) begin
        while (q.size() > 0) begin
            exp_v = q.pop_front();
            `CHK({mode_o, sw_o, fail, dg, og, tg, emu, l1, lkd, pg}, exp_v)
        end
    end

    task automatic end_sim;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Cuts a hung run short.
    initial begin
        repeat (5000) @(posedge core_clk_in);
        n_errors++;
        end_sim();
    end

    initial begin
        void'($urandom(16));
        rst();
        step(0, 0, 0, 0, 1, 0, 8'h5A);
        step(1, 0, 0, 0, 1, 0, 8'h3C);
        step(0, 0, 0, 0, 1, 0, 8'h11);
        step(0, 0, 1, 0, 0, 0, 8'h00);
        step(0, 1, 0, 0, 0, 0, 8'h00);
        step(1, 0, 0, 0, 0, 0, 8'h00);
        step(0, 0, 0, 1, 0, 0, 8'h00);
        repeat (2) step(0, 0, 0, 0, 0, 0, 8'h00);
        step(1, 0, 0, 0, 0, 0, 8'h00);
        step(0, 1, 1, 0, 0, 0, 8'h00);
        step(1, 0, 0, 0, 0, 0, 8'h00);
        repeat (4) step(0, 0, 0, 0, 0, 0, 8'h00);
        step(0, 1, 0, 0, 1, 0, 8'h77);
        step(1, 0, 0, 0, 0, 0, 8'h00);
        for (int i = 0; i < 6; i++) step(0, 0, 0, i[0], 1, 0, 8'($urandom));
        step(0, 0, 0, 0, 0, 1, 8'h00);
        repeat (2) step(0, 0, 0, 0, 0, 0, 8'h00);
        rst();
        repeat (2) step(0, 0, 0, 0, 1, 0, 8'h81);
        end_sim();
    end
endmodule
`default_nettype wire
